// *** hdl/adc_regs_pkg.sv ***
// Constants, field layouts and types for the converter register bank.
// Assumes a single 10 MHz system clock and a 16-clock serial frame.
// What this block does
// (RL1) Read-only result register holds latest sample
// (RL2) Sample in bits 11:0, resets zero
// (RL3) Converted input index in bits 15:13
// (RL4) Limit event flag in bit 12
// (RL5) Unused tag bits read zero on small parts
// (RL6) Channel register: one select bit per input
// (RL7) New selection starts one conversion late
// (RL8) New selection restarts at lowest enabled input
// (RL9) Configuration register with documented bit layout
// (RL10) Frame is 16 clocks: address then direction
// (RL11) Write at select rise; read next frame
// (RL12) Soft reset clears logic, self-clears next cycle
// (RL13) Reserved bits read zero, writes ignored
package adc_regs_pkg;
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_BITS_5 = 5'h10;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 11;
	localparam int DIR_BIT = 10;
	localparam logic [4:0] ADDR_RESULT = 5'h00;
	localparam logic [4:0] ADDR_CHANNEL = 5'h01;
	localparam logic [4:0] ADDR_SETUP = 5'h02;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [11:0] SAMPLE_RESET = 12'h000;
	localparam logic [7:0] CHANNEL_RESET = 8'h00;
	localparam logic [15:0] SETUP_RESET = 16'h00C0;
	localparam logic [15:0] SETUP_WMASK = 16'h02FF;
	localparam logic [7:0] CHANNEL_WMASK = 8'hFF;
	localparam int NUM_INPUTS_DEFAULT = 8;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic [2:0] converted_input_tag;
		logic limit_event;
		logic [11:0] sample;
	} result_t;

	typedef struct packed {
		logic [5:0] reserved_hi;
		logic soft_reset_bit;
		logic reserved_b8;
		logic event_latching;
		logic event_drive_cmos;
		logic busy_indication;
		logic event_pin_function_select;
		logic event_polarity_or_output0_level;
		logic general_output_one_level;
		logic [1:0] power_mode;
	} setup_t;

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b01,
		LINK_FRAME = 2'b10
	} link_state_t;
endpackage

// *** hdl/pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins change no faster than a few system clocks.
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta <= pin_i;
			sync_o <= meta;
		end
	end
endmodule // pin_sync

// *** hdl/adc_result_channel_config_regs.sv ***
// Result, channel and configuration registers behind the serial port.
// Assumes conversion strobes arrive on mclk_i; serial pins are asynchronous.
`timescale 1ns/10ps
module adc_result_channel_config_regs #(
	parameter int NUM_INPUTS = adc_regs_pkg::NUM_INPUTS_DEFAULT
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	input wire logic conv_done_i,
	input wire logic [11:0] conv_data_i,
	input wire logic limit_event_i,
	input wire logic limit_clear_i,
	output logic [2:0] conv_input_o,
	output logic [7:0] input_select_o,
	output adc_regs_pkg::setup_t setup_o
);
	logic [2:0] pins_s;
	logic cs_high;
	logic sclk_s;
	logic sdi_s;
	logic cs_d;
	logic sclk_d;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	adc_regs_pkg::link_state_t link_state;
	logic [15:0] rx;
	logic [15:0] tx;
	logic [4:0] bit_cnt;
	logic read_pending;
	logic [4:0] read_addr;
	logic frame_is_result;
	logic commit;
	logic commit_write;
	logic [4:0] rx_addr;
	adc_regs_pkg::result_t result;
	logic [7:0] channel;
	adc_regs_pkg::setup_t setup;
	logic soft_rst;
	logic [7:0] seq_active;
	logic [7:0] seq_pending;
	logic pending_valid;
	logic [2:0] current;
	logic [2:0] tag_mask;
	logic [15:0] next_tx;
	logic [15:0] setup_view;
	logic alert_clear;

	function automatic logic [2:0] lowest_set(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (v[i])
			begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [2:0] next_set(input logic [7:0] v, input logic [2:0] cur);
		logic [2:0] idx;
		logic found;
		idx = lowest_set(v);
		found = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (!found && v[i] && (3'(i) > cur))
			begin
				idx = 3'(i);
				found = 1'b1;
			end
		end
		return idx;
	endfunction

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		// Select enters inverted so the zero reset of the flops means idle, no false frame
		.pin_i({!cs_n_i, sclk_i, sdi_i}),
		.sync_o(pins_s)
	);

	assign cs_high = !pins_s[2];
	assign sclk_s = pins_s[1];
	assign sdi_s = pins_s[0];
	assign sclk_rise = sclk_s && !sclk_d && !cs_high;
	assign sclk_fall = !sclk_s && sclk_d && !cs_high;
	assign cs_fall = !cs_high && cs_d;
	assign cs_rise = cs_high && !cs_d;
	assign rx_addr = rx[adc_regs_pkg::ADDR_MSB:adc_regs_pkg::ADDR_LSB];
	// Short or long frames are dropped whole rather than half-applied
	assign commit = cs_rise && (link_state == adc_regs_pkg::LINK_FRAME)
		&& (bit_cnt == adc_regs_pkg::FRAME_BITS_5); // [RL10]
	assign commit_write = commit && rx[adc_regs_pkg::DIR_BIT]; // [RL11]
	assign tag_mask = (NUM_INPUTS <= 2) ? 3'h1 : ((NUM_INPUTS <= 4) ? 3'h3 : 3'h7);
	assign soft_rst = setup.soft_reset_bit;

	// Busy indication reads back only when the event pin function is on
	always_comb
	begin
		setup_view = setup;
		setup_view[5] = setup.busy_indication && setup.event_pin_function_select;
	end

	// Register chosen by the previous read request, zero if unmapped
	always_comb
	begin
		next_tx = 16'h0000;
		if (!read_pending || read_addr == adc_regs_pkg::ADDR_RESULT)
		begin
			next_tx = result;
		end
		else if (read_addr == adc_regs_pkg::ADDR_CHANNEL)
		begin
			next_tx = {8'h00, channel}; // [RL13]
		end
		else if (read_addr == adc_regs_pkg::ADDR_SETUP)
		begin
			next_tx = setup_view;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cs_d <= 1'b1;
			sclk_d <= 1'b0;
		end
		else
		begin
			cs_d <= cs_high;
			sclk_d <= sclk_s;
		end
	end

	// Frame tracking: bits sampled on serial clock rise, MSB first
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			link_state <= adc_regs_pkg::LINK_IDLE;
			bit_cnt <= 5'h00;
			rx <= 16'h0000;
		end
		else
		begin
			case (link_state)
				adc_regs_pkg::LINK_IDLE:
				begin
					if (cs_fall)
					begin
						link_state <= adc_regs_pkg::LINK_FRAME;
						bit_cnt <= 5'h00;
					end
				end
				adc_regs_pkg::LINK_FRAME:
				begin
					if (cs_high)
					begin
						link_state <= adc_regs_pkg::LINK_IDLE;
					end
					else if (sclk_rise)
					begin
						rx <= {rx[14:0], sdi_s}; // [RL10]
						if (bit_cnt != 5'h1F)
						begin
							bit_cnt <= bit_cnt + 5'h01;
						end
					end
				end
				default:
				begin
					link_state <= adc_regs_pkg::LINK_IDLE;
				end
			endcase
		end
	end

	// Output shifter: loaded at select fall, advanced on clock fall
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tx <= 16'h0000;
			sdo_o <= 1'b0;
			sdo_oe_n_o <= 1'b1;
			frame_is_result <= 1'b0;
		end
		else if (cs_fall)
		begin
			tx <= next_tx; // [RL11]
			sdo_o <= next_tx[15];
			sdo_oe_n_o <= 1'b0;
			frame_is_result <= !read_pending || read_addr == adc_regs_pkg::ADDR_RESULT;
		end
		else if (cs_high)
		begin
			sdo_oe_n_o <= 1'b1;
		end
		else if (sclk_fall)
		begin
			tx <= {tx[14:0], 1'b0};
			sdo_o <= tx[14];
		end
	end

	// Read requests aim the next frame; a committed write returns the result, a dropped frame keeps the earlier aim
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			read_pending <= 1'b0;
			read_addr <= adc_regs_pkg::ADDR_RESULT;
		end
		else if (soft_rst)
		begin
			read_pending <= 1'b0;
			read_addr <= adc_regs_pkg::ADDR_RESULT;
		end
		else if (commit)
		begin
			read_pending <= !rx[adc_regs_pkg::DIR_BIT]; // [RL11]
			read_addr <= rx_addr;
		end
	end

	// Channel select bits; reserved upper bits are not stored
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			channel <= adc_regs_pkg::CHANNEL_RESET; // [RL6]
		end
		else if (commit_write && rx_addr == adc_regs_pkg::ADDR_CHANNEL)
		begin
			channel <= rx[7:0] & adc_regs_pkg::CHANNEL_WMASK; // [RL6] [RL13]
		end
	end

	// Configuration; the soft reset bit drops again after one cycle
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			setup <= adc_regs_pkg::SETUP_RESET; // [RL9]
		end
		else if (commit_write && rx_addr == adc_regs_pkg::ADDR_SETUP)
		begin
			setup <= rx & adc_regs_pkg::SETUP_WMASK; // [RL9] [RL13]
		end
		else if (setup.soft_reset_bit)
		begin
			setup.soft_reset_bit <= 1'b0; // [RL12]
		end
	end

	// Sequencer: a new selection waits one conversion, then restarts low
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			seq_active <= adc_regs_pkg::CHANNEL_RESET;
			seq_pending <= adc_regs_pkg::CHANNEL_RESET;
			pending_valid <= 1'b0;
			current <= 3'h0;
		end
		else if (soft_rst)
		begin
			seq_active <= channel; // [RL12]
			seq_pending <= channel;
			pending_valid <= 1'b0;
			current <= lowest_set(channel);
		end
		else
		begin
			if (commit_write && rx_addr == adc_regs_pkg::ADDR_CHANNEL)
			begin
				seq_pending <= rx[7:0];
				pending_valid <= 1'b1; // [RL7]
			end
			else if (conv_done_i && pending_valid)
			begin
				pending_valid <= 1'b0;
			end
			if (conv_done_i)
			begin
				if (pending_valid)
				begin
					seq_active <= seq_pending; // [RL7]
					current <= lowest_set(seq_pending); // [RL8]
				end
				else
				begin
					current <= next_set(seq_active, current);
				end
			end
		end
	end

	// A read of the result in latching mode clears the limit flag
	assign alert_clear = (cs_rise && frame_is_result && setup.event_latching)
		|| (limit_clear_i && !setup.event_latching);

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			result <= adc_regs_pkg::RESULT_RESET;
		end
		else if (soft_rst)
		begin
			result <= adc_regs_pkg::RESULT_RESET; // [RL12]
		end
		else
		begin
			if (conv_done_i)
			begin
				result.sample <= conv_data_i; // [RL1] [RL2]
				result.converted_input_tag <= current & tag_mask; // [RL3] [RL5]
			end
			// Set beats clear so an event in the clearing cycle survives
			if (limit_event_i)
			begin
				result.limit_event <= 1'b1; // [RL4]
			end
			else if (alert_clear)
			begin
				result.limit_event <= 1'b0;
			end
		end
	end

	assign conv_input_o = current & tag_mask;
	assign input_select_o = seq_active;
	assign setup_o = setup;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_sample_update: assert property (conv_done_i && !soft_rst
		|=> result.sample == $past(conv_data_i)) // [RL1] [RL2]
		else $error("sample not stored after conversion");
	a_tag_match: assert property (conv_done_i && !soft_rst
		|=> result.converted_input_tag == ($past(current) & tag_mask)) // [RL3]
		else $error("input tag does not match converted input");
	a_tag_unused_zero: assert property ((result.converted_input_tag & ~tag_mask) == 3'h0) // [RL5]
		else $error("unused tag bit set");
	a_limit_set: assert property (limit_event_i && !soft_rst
		|=> result.limit_event) // [RL4]
		else $error("limit event lost");
	a_reserved_zero: assert property (setup.reserved_hi == 6'h00 && !setup.reserved_b8) // [RL13]
		else $error("reserved configuration bit set");
	a_soft_selfclear: assert property (soft_rst
		|=> !setup.soft_reset_bit && result == adc_regs_pkg::RESULT_RESET) // [RL12]
		else $error("soft reset did not clear");
	a_select_latency: assert property (commit_write && rx_addr == adc_regs_pkg::ADDR_CHANNEL
		&& !conv_done_i && !soft_rst |=> $stable(seq_active) && pending_valid) // [RL7]
		else $error("new selection applied too early");
	a_restart_lowest: assert property (conv_done_i && pending_valid && !soft_rst
		&& !commit_write |=> current == lowest_set($past(seq_pending))) // [RL8]
		else $error("sequence did not restart at lowest input");
	a_setup_write: assert property (commit_write && rx_addr == adc_regs_pkg::ADDR_SETUP
		|=> setup[7:0] == $past(rx[7:0])) // [RL9] [RL11]
		else $error("configuration write not applied");
	a_read_next: assert property (commit && !rx[adc_regs_pkg::DIR_BIT] && !soft_rst
		|=> read_pending && read_addr == $past(rx_addr)) // [RL11]
		else $error("read request not held for next frame");
	a_frame_load: assert property (cs_fall |=> sdo_o == $past(next_tx[15]) && !sdo_oe_n_o) // [RL10]
		else $error("first output bit not loaded at frame start");
endmodule // adc_result_channel_config_regs

// *** sim/spi_host_model.sv ***
// Serial host model: frames 16-bit words to the register bank.
// Assumes the bench clock on mclk_i; serial clock is 8 mclk per period.
`timescale 1ns/10ps
module spi_host_model (
	input wire logic mclk_i,
	input wire logic sdo_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end

	task step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// Read data is taken late in the high phase, before the shifting fall
	task xfer(input logic [15:0] tx, output logic [15:0] rx);
		cs_n_o = 1'b0;
		step(4);
		for (int i = 15; i >= 0; i--)
		begin
			sdi_o = tx[i];
			step(4);
			sclk_o = 1'b1;
			step(3);
			rx[i] = sdo_i;
			step(1);
			sclk_o = 1'b0;
		end
		step(4);
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		step(8);
	endtask
endmodule // spi_host_model

// *** sim/test_adc_result_channel_config_regs.sv ***
// Self-checking bench for the result, channel and setup registers.
// Assumes spi_host_model as the serial host; conversions driven here.
`timescale 1ns/10ps
module test_adc_result_channel_config_regs;
	logic mclk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe_n, done, lim, lclr;
	logic [11:0] data;
	logic [2:0] cin;
	logic [7:0] isel;
	logic [15:0] rx;
	adc_regs_pkg::setup_t setup;
	int fail_count;
	int comparisons;
	logic [2:0] tags [4] = '{3'h2, 3'h5, 3'h7, 3'h2};
	logic sdo_line;

	adc_result_channel_config_regs #(.NUM_INPUTS(8)) uut (.mclk_i(mclk), .reset_n_i(rst_n),
		.cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
		.conv_done_i(done), .conv_data_i(data), .limit_event_i(lim), .limit_clear_i(lclr),
		.conv_input_o(cin), .input_select_o(isel), .setup_o(setup));
	spi_host_model host (.mclk_i(mclk), .sdo_i(sdo_line), .cs_n_o(cs_n), .sclk_o(sclk),
		.sdi_o(sdi));

	// Released line shows the inverse, so a late enable corrupts the read word
	assign sdo_line = sdo_oe_n ? ~sdo : sdo;

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Every frame shifts out what the frame before it asked for
	task xf(input logic [15:0] tx, input logic [15:0] exp);
		host.xfer(tx, rx);
		chk(rx, exp);
	endtask

	task conv(input logic [11:0] d);
		done = 1'b1;
		data = d;
		host.step(1);
		done = 1'b0;
		data = ~d;
		host.step(1);
	endtask

	// One-cycle pulses on the limit event and clear inputs
	task side(input logic ev, input logic clr);
		lim = ev;
		lclr = clr;
		host.step(1);
		lim = 1'b0;
		lclr = 1'b0;
	endtask

	task summarize;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#2_000_000;
		fail_count++;
		summarize;
	end

	initial
	begin
		rst_n = 1'b0;
		done = 1'b0;
		lim = 1'b0;
		lclr = 1'b0;
		data = 12'h000;
		host.step(12);
		rst_n = 1'b1;
		host.step(4);
		chk(setup, 16'h00C0);
		chk({8'h00, isel}, 16'h0000);
		xf(16'h1000, 16'h0000);
		xf(16'h0800, 16'h00C0);
		xf(16'h0000, 16'h0000);
		conv(12'h123);
		xf(16'h0CA4, 16'h0123);
		conv(12'hFFF);
		xf(16'h0800, 16'h0FFF);
		xf(16'h0000, 16'h00A4);
		chk({13'h0000, cin}, 16'h0002);
		foreach (tags[k])
		begin
			conv(12'h800 | 12'(k));
			xf(16'h0000, {tags[k], 1'b0, 12'h800 | 12'(k)});
		end
		// Clear input must lose while latching is set
		side(1'b1, 1'b0);
		side(1'b0, 1'b1);
		conv(12'h055);
		xf(16'h0000, 16'hB055);
		xf(16'h15FF, 16'hA055);
		xf(16'h1000, 16'hA055);
		xf(16'h0000, 16'h00FF);
		chk(setup, 16'h00FF);
		xf(16'h14EF, 16'hA055);
		xf(16'h1000, 16'hA055);
		xf(16'h0000, 16'h00CF);
		xf(16'h16CF, 16'hA055);
		xf(16'h1000, 16'h0000);
		xf(16'h0000, 16'h00CF);
		chk({8'h00, isel}, 16'h00A4);
		conv(12'h321);
		xf(16'h2800, 16'h4321);
		xf(16'h0555, 16'h0000);
		xf(16'h0000, 16'h4321);
		// Latching off: reads keep the flag, the clear input drops it
		xf(16'h144F, 16'h4321);
		side(1'b1, 1'b0);
		conv(12'h0AB);
		xf(16'h0000, 16'hB0AB);
		xf(16'h0000, 16'hB0AB);
		side(1'b1, 1'b1);
		xf(16'h0000, 16'hB0AB);
		side(1'b0, 1'b1);
		xf(16'h0000, 16'hA0AB);
		summarize;
	end
endmodule // test_adc_result_channel_config_regs
